/* uinfc_pkg.sv */
package uinfc_pkg;
    // endpoint count and register indices; byte address is index times four
    localparam int unsigned NUM_EP       = 5;
    localparam logic [7:0]  NAK_FLAG_IDX = 8'hEB;
    localparam logic [7:0]  CTRL_IDX     = 8'hEC;
    localparam logic [7:0]  STAT_IDX     = 8'hF8;

    // values after reset
    localparam logic [4:0]  FLAG_RST     = 5'h00;
    localparam logic [2:0]  CTRL_RST     = 3'h0;
    localparam logic [1:0]  STAT_RST     = 2'h0;
    localparam logic [4:0]  READY_RST    = 5'h00;

    // field positions
    localparam int unsigned WAKE_BIT     = 0;
    localparam int unsigned WIN_BIT      = 1;
    localparam int unsigned EN_BIT       = 2;
    localparam int unsigned RESUME_BIT   = 0;
    localparam int unsigned SUSPEND_BIT  = 1;

    // flags that stay live when endpoint fifos are paired, and when they are not
    localparam logic [4:0]  ODD_EP_MASK  = 5'h0A;
    localparam logic [4:0]  ALL_EP_MASK  = 5'h1F;

    // token answer state
    typedef enum logic [2:0] {
        RESP_IDLE = 3'b001,
        RESP_DATA = 3'b010,
        RESP_NAK  = 3'b100
    } uinfc_resp_t;
endpackage

/* uinfc_top.sv */
`timescale 1ns/1ns
module uinfc_top #(
    parameter int unsigned ADDR_W = 10
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // serial engine events
    input  wire logic              inToken,
    input  wire logic [2:0]        tokenEp,
    input  wire logic              sizeWrite,
    input  wire logic [2:0]        sizeEp,
    input  wire logic              inSent,
    input  wire logic [2:0]        sentEp,
    input  wire logic              suspendDet,
    input  wire logic              pairMode,
    // bus activity pin
    input  wire logic              busActivity,
    // serial engine control
    output logic                   tokenRespEn,
    output logic                   dataResp,
    output logic                   nakResp,
    output logic                   reinitEngine,
    output logic                   ep0StatClr,
    output logic                   epCtrlClr,
    output logic                   engineClkEn,
    output logic                   fifoWinEn,
    // data line drive
    output logic                   wakeDpO,
    output logic                   wakeDmO,
    output logic                   wakeOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // index field needs bits 9:2; wider buses alias above them
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie in 10..32");
    end

    // endpoint number to one-hot, zero when out of range
    function automatic logic [4:0] epOneHot(input logic [2:0] ep);
        logic [4:0] m;
        m = 5'h00;
        if (ep < 3'(uinfc_pkg::NUM_EP)) begin
            m[ep] = 1'b1;
        end
        return m;
    endfunction

    logic [4:0]             flag_r;
    logic [4:0]             flag_nxt;
    logic [4:0]             ready_r;
    logic [2:0]             ctrl_r;
    logic [2:0]             ctrl_nxt;
    logic [1:0]             stat_r;
    logic [1:0]             stat_nxt;
    uinfc_pkg::uinfc_resp_t resp_r;
    logic                   act1_r;
    logic                   act2_r;
    logic                   wrPend_r;
    logic [7:0]             wrIdx_r;
    logic                   reinit_r;
    logic                   clkEn_r;
    logic [31:0]            hrdata_r;
    logic                   addrPhase;
    logic [7:0]             addrIdx;
    logic                   wrFlag;
    logic                   wrCtrl;
    logic                   wrStat;
    logic [4:0]             tokMask;
    logic [4:0]             liveMask;
    logic [4:0]             nakSet;
    logic [4:0]             clrMask;
    logic                   tokTaken;
    logic                   resumeSet;

    // bus decode
    assign addrPhase = hsel & hready & htrans[1];
    assign addrIdx   = haddr[9:2];
    assign wrFlag    = wrPend_r && wrIdx_r == uinfc_pkg::NAK_FLAG_IDX;
    assign wrCtrl    = wrPend_r && wrIdx_r == uinfc_pkg::CTRL_IDX;
    assign wrStat    = wrPend_r && wrIdx_r == uinfc_pkg::STAT_IDX;

    // token path
    assign tokMask  = epOneHot(tokenEp);
    assign tokTaken = inToken & ctrl_r[uinfc_pkg::EN_BIT] & (|tokMask);
    assign liveMask = pairMode ? uinfc_pkg::ODD_EP_MASK
                               : uinfc_pkg::ALL_EP_MASK;
    assign nakSet   = tokTaken ? (tokMask & ~ready_r & liveMask)
                               : 5'h00;
    // zero written clears, one written keeps
    assign clrMask  = wrFlag ? ~hwdata[4:0] : 5'h00;
    // own drive of K must not look like host resume
    assign resumeSet = act2_r & stat_r[uinfc_pkg::SUSPEND_BIT]
                     & ~ctrl_r[uinfc_pkg::WAKE_BIT];

    always_comb begin
        flag_nxt = (flag_r & ~clrMask) | nakSet;
        ctrl_nxt = wrCtrl ? hwdata[2:0] : ctrl_r;
        stat_nxt = stat_r;
        if (wrStat) begin
            stat_nxt = stat_r & hwdata[1:0];
        end
        // set beats a clear in the same cycle
        if (resumeSet) begin
            stat_nxt[uinfc_pkg::RESUME_BIT] = 1'b1;
        end
        if (suspendDet) begin
            stat_nxt[uinfc_pkg::SUSPEND_BIT] = 1'b1;
        end
    end

    // pin synchroniser, first stage read only by the second
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            act1_r <= 1'b0;
            act2_r <= 1'b0;
        end else begin
            act1_r <= busActivity;
            act2_r <= act1_r;
        end
    end

    // ahb data phase capture
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrPend_r <= 1'b0;
            wrIdx_r  <= 8'h00;
        end else if (hready) begin
            wrPend_r <= addrPhase & hwrite;
            wrIdx_r  <= addrIdx;
        end
    end

    // read data taken from next state so a write just before is seen
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addrPhase & ~hwrite) begin
            unique case (addrIdx)
                uinfc_pkg::NAK_FLAG_IDX:
                    hrdata_r <= {27'h0, flag_nxt & liveMask};
                uinfc_pkg::CTRL_IDX:
                    hrdata_r <= {29'h0, ctrl_nxt};
                uinfc_pkg::STAT_IDX:
                    hrdata_r <= {30'h0, stat_nxt};
                default:
                    hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // nak flags
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_r <= uinfc_pkg::FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // control register, untouched by usb bus reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= uinfc_pkg::CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // suspend and resume status
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stat_r <= uinfc_pkg::STAT_RST;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // engine clock gate on its own flop so the pin sees no decode glitch
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clkEn_r <= ~uinfc_pkg::STAT_RST[uinfc_pkg::SUSPEND_BIT];
        end else begin
            clkEn_r <= ~stat_nxt[uinfc_pkg::SUSPEND_BIT];
        end
    end

    // re-enable pulse, one cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reinit_r <= 1'b0;
        end else begin
            reinit_r <= ctrl_nxt[uinfc_pkg::EN_BIT]
                      & ~ctrl_r[uinfc_pkg::EN_BIT];
        end
    end

    // fifo ready state; size write wins over a finished send
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ready_r <= uinfc_pkg::READY_RST;
        end else if (reinit_r) begin
            ready_r <= uinfc_pkg::READY_RST;
        end else begin
            ready_r <= (ready_r & ~(inSent ? epOneHot(sentEp) : 5'h00))
                     | (sizeWrite ? epOneHot(sizeEp) : 5'h00);
        end
    end

    // token answer
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resp_r <= uinfc_pkg::RESP_IDLE;
        end else if (!tokTaken) begin
            resp_r <= uinfc_pkg::RESP_IDLE;
        end else if (|(tokMask & ready_r)) begin
            resp_r <= uinfc_pkg::RESP_DATA;
        end else begin
            resp_r <= uinfc_pkg::RESP_NAK;
        end
    end

    assign hrdata       = hrdata_r;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign tokenRespEn  = ctrl_r[uinfc_pkg::EN_BIT];
    assign fifoWinEn    = ctrl_r[uinfc_pkg::WIN_BIT];
    assign dataResp     = resp_r[1];
    assign nakResp      = resp_r[2];
    assign reinitEngine = reinit_r;
    assign ep0StatClr   = reinit_r;
    assign epCtrlClr    = reinit_r;
    // suspend gates the engine clock; clearing it restarts
    assign engineClkEn  = clkEn_r;
    // K state: D+ low, D- high; timing is left to software
    assign wakeOe       = ctrl_r[uinfc_pkg::WAKE_BIT];
    assign wakeDmO      = ctrl_r[uinfc_pkg::WAKE_BIT];
    assign wakeDpO      = 1'b0;

    property p_nak_flag;
        logic [4:0] m;
        (tokTaken && (tokMask & ~ready_r & liveMask) != 5'h00,
         m = tokMask) |=> ((flag_r & m) == m);
    endproperty
    a_nak_flag: assert property (p_nak_flag)
        else $error("nak flag not set after nak");

    property p_size_ready;
        logic [4:0] m;
        (sizeWrite && !reinit_r && epOneHot(sizeEp) != 5'h00,
         m = epOneHot(sizeEp)) |=> ((ready_r & m) == m);
    endproperty
    a_size_ready: assert property (p_size_ready)
        else $error("size write did not make fifo ready");

    property p_nak_unready;
        tokTaken && (tokMask & ready_r) == 5'h00 |=> nakResp && !dataResp;
    endproperty
    a_nak_unready: assert property (p_nak_unready)
        else $error("unready endpoint not answered with nak");

    property p_flag_holds;
        1'b1 |=> (($past(flag_r) & ~$past(clrMask) & ~flag_r) == 5'h00);
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("nak flag dropped without clearing write");

    property p_pair_even;
        pairMode |=> ((flag_r & ~$past(flag_r) & ~uinfc_pkg::ODD_EP_MASK)
                      == 5'h00);
    endproperty
    a_pair_even: assert property (p_pair_even)
        else $error("even flag set while paired");

    property p_disabled_quiet;
        !tokenRespEn |=> !nakResp && !dataResp;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("token answered while disabled");

    property p_reinit;
        $rose(tokenRespEn) |-> reinitEngine && ep0StatClr
                               ##1 !reinitEngine && ready_r == 5'h00;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("re-enable did not reinitialise");

    property p_wake_k;
        wakeOe |-> wakeDmO && !wakeDpO;
    endproperty
    a_wake_k: assert property (p_wake_k)
        else $error("wakeup drive is not K");

    property p_wake_no_resume;
        wakeOe && !stat_r[uinfc_pkg::RESUME_BIT] && !wrStat
            |=> !stat_r[uinfc_pkg::RESUME_BIT];
    endproperty
    a_wake_no_resume: assert property (p_wake_no_resume)
        else $error("wakeup set the resume flag");

    property p_resume;
        act2_r && !engineClkEn && !wakeOe |=> stat_r[uinfc_pkg::RESUME_BIT];
    endproperty
    a_resume: assert property (p_resume)
        else $error("activity in suspend did not set resume");

    property p_ctrl_hold;
        !wrCtrl |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control changed without a write");

    property p_clk_restart;
        $fell(stat_r[uinfc_pkg::SUSPEND_BIT]) |-> engineClkEn;
    endproperty
    a_clk_restart: assert property (p_clk_restart)
        else $error("engine clock not restarted after suspend clear");

    c_nak:    cover property (tokTaken ##1 nakResp);
    c_data:   cover property (sizeWrite ##[1:20] dataResp);
    c_reinit: cover property (!tokenRespEn ##1 tokenRespEn);
    c_resume: cover property (!engineClkEn ##[1:50] resumeSet);
endmodule

/* uinfc_host_model.sv */
`timescale 1ns/1ns
module uinfc_host_model (
    // clock
    input  wire logic  ref_clk,
    // engine events
    output logic       inToken,
    output logic [2:0] tokenEp,
    output logic       sizeWrite,
    output logic [2:0] sizeEp,
    output logic       inSent,
    output logic [2:0] sentEp,
    output logic       suspendDet,
    // bus pin
    output logic       busActivity
);
    initial begin
        {inToken, sizeWrite, inSent, suspendDet, busActivity} = 5'h00;
        {tokenEp, sizeEp, sentEp} = 9'h000;
    end

    // k: 0 token, 1 size write, 2 sent, 3 suspend; one-cycle pulse
    task automatic ev(input int k, input logic [2:0] ep);
        @(posedge ref_clk);
        inToken <= (k == 0);
        sizeWrite <= (k == 1);
        inSent <= (k == 2);
        suspendDet <= (k == 3);
        {tokenEp, sizeEp, sentEp} <= {3{ep}};
        @(posedge ref_clk);
        {inToken, sizeWrite, inSent, suspendDet} <= 4'h0;
        // released selects flip so a stale endpoint never matches
        {tokenEp, sizeEp, sentEp} <= {3{~ep}};
    endtask

    task automatic act(input logic lvl);
        @(posedge ref_clk);
        busActivity <= lvl;
    endtask
endmodule

/* uinfc_top_tb.sv */
`timescale 1ns/1ns
module uinfc_top_tb;
    localparam logic [9:0] A_FLAG = 10'h3AC;
    localparam logic [9:0] A_CTRL = 10'h3B0;
    localparam logic [9:0] A_STAT = 10'h3E0;
    localparam logic [9:0] A_NONE = 10'h3FC;
    logic ref_clk, reset, hsel, hwrite, pairMode, rdPend;
    logic [9:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, tokenEp, sizeEp, sentEp;
    logic [31:0] hwdata, hrdata, lf;
    logic hreadyout, hresp, inToken, sizeWrite, inSent, suspendDet;
    logic busActivity, tokenRespEn, dataResp, nakResp, reinitEngine;
    logic ep0StatClr, epCtrlClr, engineClkEn, fifoWinEn;
    logic wakeDpO, wakeDmO, wakeOe;
    logic [31:0] expQ[$];
    logic [1:0] rq[$];
    int n_mismatch = 0;
    int samples_checked = 0;

    uinfc_top uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .inToken(inToken),
        .tokenEp(tokenEp), .sizeWrite(sizeWrite), .sizeEp(sizeEp),
        .inSent(inSent), .sentEp(sentEp), .suspendDet(suspendDet),
        .pairMode(pairMode), .busActivity(busActivity),
        .tokenRespEn(tokenRespEn), .dataResp(dataResp), .nakResp(nakResp),
        .reinitEngine(reinitEngine), .ep0StatClr(ep0StatClr),
        .epCtrlClr(epCtrlClr), .engineClkEn(engineClkEn),
        .fifoWinEn(fifoWinEn), .wakeDpO(wakeDpO), .wakeDmO(wakeDmO),
        .wakeOe(wakeOe));
    uinfc_host_model hm (.ref_clk(ref_clk), .inToken(inToken),
        .tokenEp(tokenEp), .sizeWrite(sizeWrite), .sizeEp(sizeEp),
        .inSent(inSent), .sentEp(sentEp), .suspendDet(suspendDet),
        .busActivity(busActivity));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xf(input logic wr, input logic [9:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, wr};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata, rdPend} <= {1'b0, 2'b00, d, ~wr};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdPend <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        expQ.push_back(e);
        xf(1'b0, a, 32'h0);
    endtask

    // exp {data,nak}; 00 means the token must go unanswered
    task automatic tk(input logic [2:0] ep, input logic [1:0] exp);
        if (exp != 2'b00) rq.push_back(exp);
        hm.ev(0, ep);
    endtask

    always @(posedge ref_clk) begin
        if (rdPend) begin
            chk("hrdata", hrdata, expQ.pop_front());
            chk("hresp", {31'h0, hresp}, 32'h0);
            chk("hready", {31'h0, hreadyout}, 32'h1);
        end
    end

    always @(negedge ref_clk) begin
        if (dataResp === 1'b1 || nakResp === 1'b1) begin
            if (rq.size() == 0) chk("resp", {dataResp, nakResp}, 0);
            else chk("resp", {dataResp, nakResp}, rq.pop_front());
        end
    end

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {reset, hsel, hwrite, pairMode, rdPend} = 5'h10;
        {haddr, htrans, hsize, hwdata} = {10'h000, 2'h0, 3'h2, 32'h0};
        lf = 32'd77916;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rd(A_FLAG, 32'h0);
        rd(A_CTRL, 32'h0);
        rd(A_NONE, 32'h0);
        tk(3'd1, 2'b00);
        rd(A_FLAG, 32'h0);
        $display("test reset and disabled done");
        xf(1'b1, A_CTRL, 32'h4);
        @(negedge ref_clk);
        chk("reinit", {reinitEngine, ep0StatClr, epCtrlClr}, 3'h7);
        chk("enable", {31'h0, tokenRespEn}, 32'h1);
        hm.ev(1, 3'd2);
        for (int e = 0; e < 5; e++) tk(3'(e), e == 2 ? 2'b10 : 2'b01);
        tk(3'd5, 2'b00);
        rd(A_FLAG, 32'h1B);
        hm.ev(2, 3'd2);
        tk(3'd2, 2'b01);
        tk(3'd2, 2'b01);
        rd(A_FLAG, 32'h1F);
        xf(1'b1, A_FLAG, 32'hFF);
        rd(A_FLAG, 32'h1F);
        lf = lfsr(lf);
        xf(1'b1, A_FLAG, lf);
        rd(A_FLAG, lf & 32'h1F);
        xf(1'b1, A_FLAG, 32'h0);
        rd(A_FLAG, 32'h0);
        $display("test tokens and flags done");
        pairMode <= 1'b1;
        for (int e = 0; e < 5; e++) tk(3'(e), 2'b01);
        rd(A_FLAG, 32'h0A);
        pairMode <= 1'b0;
        xf(1'b1, A_FLAG, 32'h0);
        $display("test paired done");
        xf(1'b1, A_CTRL, 32'h7);
        @(negedge ref_clk);
        chk("window", {31'h0, fifoWinEn}, 32'h1);
        chk("wake", {wakeOe, wakeDmO, wakeDpO}, 3'b110);
        rd(A_CTRL, 32'h7);
        // wake held only a few cycles here; real span is software's
        hm.ev(3, 3'd0);
        hm.act(1'b1);
        repeat (4) @(posedge ref_clk);
        rd(A_STAT, 32'h2);
        @(negedge ref_clk);
        chk("clkEn", {31'h0, engineClkEn}, 32'h0);
        xf(1'b1, A_CTRL, 32'h4);
        repeat (4) @(posedge ref_clk);
        rd(A_STAT, 32'h3);
        hm.act(1'b0);
        xf(1'b1, A_STAT, 32'h0);
        rd(A_STAT, 32'h0);
        @(negedge ref_clk);
        chk("clkEn", {31'h0, engineClkEn}, 32'h1);
        chk("pending", rq.size(), 32'h0);
        $display("test control and resume done");
        wrap_up();
    end
endmodule
